// >>> src/qps_cfg.svh
// constants: offsets, field layout, presets and serial address of the preset selector
`ifndef QPS_CFG_SVH
`define QPS_CFG_SVH

// -----------------------------------------
// bus map: set n field f at n*0x10 + f*4
// -----------------------------------------
`define QPS_STATUS_OFS 8'h40
`define QPS_REF_OFS    8'h44
`define QPS_FLD_PRE    2'h0
`define QPS_FLD_WHOLE  2'h1
`define QPS_FLD_FRAC   2'h2
`define QPS_FLD_POST   2'h3

// -----------------------------------------
// serial byte map: set n byte i at n*8 + i
// -----------------------------------------
`define QPS_B_PRE      3'h0
`define QPS_B_WHOLE    3'h1
`define QPS_B_FRAC_H   3'h2
`define QPS_B_FRAC_M   3'h3
`define QPS_B_FRAC_L   3'h4
`define QPS_B_POST     3'h5
// arbitrary device address
`define QPS_DEV_ADDR   7'h6e

// -----------------------------------------
// presets {pre, whole, frac, post}, reference, pin reset
// -----------------------------------------
`define QPS_PRESET0    34'h132000014
`define QPS_PRESET1    34'h13200000a
`define QPS_PRESET2    34'h132000005
`define QPS_PRESET3    34'h103000004
`define QPS_REF_A_KHZ  32'h0001be6d
`define QPS_REF_B_KHZ  32'h000186a0
// sda, scl, oe high; both selects low
`define QPS_PIN_RESET  5'h1c

`endif

// >>> src/qps_pkg.sv
// types of the preset selector: divider set, pin bundle, serial states
package qps_pkg;

   typedef struct packed {
      logic [1:0]  pre;
      logic [6:0]  whole;
      logic [17:0] frac;
      logic [6:0]  post;
   } qps_set_t;

   typedef struct packed {
      logic       sda;
      logic       scl;
      logic       oe;
      logic [1:0] sel;
   } qps_pins_t;

   typedef enum logic [8:0] {
      st_idle  = 9'h001,
      st_addr  = 9'h002,
      st_ack_a = 9'h004,
      st_reg   = 9'h008,
      st_ack_r = 9'h010,
      st_wdata = 9'h020,
      st_ack_w = 9'h040,
      st_rdata = 9'h080,
      st_rack  = 9'h100
   } qps_state_t;

endpackage

// >>> src/qps_top.sv
// quad preset divider selector with serial and bus access
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "qps_cfg.svh"

// Function
// - enable low releases both clock outputs; high drives them
// - enable acts without waiting for any synthesized clock edge
// - two select inputs pick set 0..3, upper input most significant
// - power-up takes the set the select inputs point at, selects default low
// - every reset loads all four sets with factory presets
// - select change switches to the new set at once
// - each set holds 2-bit pre-divider and 7-bit post-divider
// - feedback is 7-bit whole part plus 18-bit fraction
// - output = ref/(pre*post) * (whole + (fraction+0.5)/2^18)
// - reference is one of two variants, 114.285 MHz or 100 MHz
// - every set is readable and writable over the serial link
// - serial clock is input only; data line only pulled low
module qps_top #(
   parameter logic REF_VARIANT = 1'b0
) (
   input  wire logic             sys_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             hsel_in,
   input  wire logic [31:0]      haddr_in,
   input  wire logic [1:0]       htrans_in,
   input  wire logic             hwrite_in,
   input  wire logic [2:0]       hsize_in,
   input  wire logic [31:0]      hwdata_in,
   input  wire logic             hready_in,
   output logic      [31:0]      hrdata_out,
   output logic                  hreadyout_out,
   output logic                  hresp_out,
   input  wire logic [1:0]       rate_choice_in,
   input  wire logic             out_enable_in,
   input  wire logic             serial_clk_in,
   input  wire logic             serial_data_pin_in,
   output logic                  serial_data_pin_out,
   output logic                  serial_data_pin_oe_n_out,
   output qps_pkg::qps_set_t     cfg_active_out,
   output logic                  clock_out_true_out,
   output logic                  clock_out_comp_out,
   output logic                  clock_out_oe_n_out
);

   // -----------------------------------------
   // field and byte access
   // -----------------------------------------
   function automatic logic [31:0] field_rd(qps_pkg::qps_set_t s, logic [1:0] f);
      case (f)
         `QPS_FLD_PRE:   field_rd = {30'h0, s.pre};
         `QPS_FLD_WHOLE: field_rd = {25'h0, s.whole};
         `QPS_FLD_FRAC:  field_rd = {14'h0, s.frac};
         default:        field_rd = {25'h0, s.post};
      endcase
   endfunction

   function automatic qps_pkg::qps_set_t field_wr(qps_pkg::qps_set_t s, logic [1:0] f, logic [31:0] d);
      field_wr = s;
      case (f)
         `QPS_FLD_PRE:   field_wr.pre = d[1:0];
         `QPS_FLD_WHOLE: field_wr.whole = d[6:0];
         `QPS_FLD_FRAC:  field_wr.frac = d[17:0];
         default:        field_wr.post = d[6:0];
      endcase
   endfunction

   function automatic logic [7:0] byte_of(qps_pkg::qps_set_t s, logic [2:0] i);
      case (i)
         `QPS_B_PRE:    byte_of = {6'h0, s.pre};
         `QPS_B_WHOLE:  byte_of = {1'b0, s.whole};
         `QPS_B_FRAC_H: byte_of = {6'h0, s.frac[17:16]};
         `QPS_B_FRAC_M: byte_of = s.frac[15:8];
         `QPS_B_FRAC_L: byte_of = s.frac[7:0];
         `QPS_B_POST:   byte_of = {1'b0, s.post};
         default:       byte_of = 8'h00;
      endcase
   endfunction

   function automatic qps_pkg::qps_set_t byte_wr(qps_pkg::qps_set_t s, logic [2:0] i, logic [7:0] d);
      byte_wr = s;
      case (i)
         `QPS_B_PRE:    byte_wr.pre = d[1:0];
         `QPS_B_WHOLE:  byte_wr.whole = d[6:0];
         `QPS_B_FRAC_H: byte_wr.frac[17:16] = d[1:0];
         `QPS_B_FRAC_M: byte_wr.frac[15:8] = d;
         `QPS_B_FRAC_L: byte_wr.frac[7:0] = d;
         `QPS_B_POST:   byte_wr.post = d[6:0];
         default:       byte_wr = s;
      endcase
   endfunction

   function automatic logic [7:0] byte_at(qps_pkg::qps_set_t [3:0] sets, logic [7:0] a);
      byte_at = (a[7:5] == 3'h0) ? byte_of(sets[a[4:3]], a[2:0]) : 8'h00;
   endfunction

   localparam qps_pkg::qps_set_t PRESETS [4] = '{`QPS_PRESET0, `QPS_PRESET1, `QPS_PRESET2, `QPS_PRESET3};

   // -----------------------------------------
   // pin synchronisers
   // -----------------------------------------
   qps_pkg::qps_pins_t pin_raw, pin_m1_q, pin_m2_q, pin_m3_q, pin_s_q, pin_s_d;
   logic               scl_prev_q, sda_prev_q;
   logic [1:0]         sel_s;
   logic               oe_s, scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

   assign pin_raw = {serial_data_pin_in, serial_clk_in, out_enable_in, rate_choice_in};
   // a bit moves only once the second and third stages agree
   assign pin_s_d = (pin_m2_q & pin_m3_q) | (pin_s_q & (pin_m2_q | pin_m3_q));
   assign sel_s = pin_s_q.sel;
   assign oe_s = pin_s_q.oe;
   assign scl_s = pin_s_q.scl;
   assign sda_s = pin_s_q.sda;
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         pin_m1_q <= `QPS_PIN_RESET;
         pin_m2_q <= `QPS_PIN_RESET;
         pin_m3_q <= `QPS_PIN_RESET;
         pin_s_q <= `QPS_PIN_RESET;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         pin_m1_q <= pin_raw;
         pin_m2_q <= pin_m1_q;
         pin_m3_q <= pin_m2_q;
         pin_s_q <= pin_s_d;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // -----------------------------------------
   // bus slave, zero wait states
   // -----------------------------------------
   qps_pkg::qps_set_t [3:0] sets_q;
   qps_pkg::qps_set_t       sel_cfg;
   qps_pkg::qps_state_t     st_q;
   logic [31:0] ahb_rd_word, hrdata_q;
   logic [3:0]  ahb_waddr_q;
   logic        ahb_take, ahb_hi_ok, ahb_is_set, ahb_wr_q, hreadyout_q, hresp_q;
   logic        i2c_wr_q, i2c_take, i2c_in_map;
   logic [7:0]  i2c_waddr_q, i2c_wdata_q;

   assign ahb_take = hsel_in & htrans_in[1] & hready_in;
   assign ahb_hi_ok = (haddr_in[31:8] == 24'h0);
   assign ahb_is_set = ahb_hi_ok & (haddr_in[7:6] == 2'b00);
   assign ahb_rd_word = ahb_is_set ? field_rd(sets_q[haddr_in[5:4]], haddr_in[3:2])
                      : (ahb_hi_ok && haddr_in[7:0] == `QPS_STATUS_OFS) ?
                        {27'h0, REF_VARIANT, (st_q != qps_pkg::st_idle), oe_s, sel_s}
                      : (ahb_hi_ok && haddr_in[7:0] == `QPS_REF_OFS) ?
                        (REF_VARIANT ? `QPS_REF_B_KHZ : `QPS_REF_A_KHZ)
                      : 32'h00000000;

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         ahb_wr_q <= 1'b0;
         ahb_waddr_q <= 4'h0;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         ahb_wr_q <= ahb_take & hwrite_in & ahb_is_set;
         ahb_waddr_q <= haddr_in[5:2];
         if (ahb_take && !hwrite_in) begin
            hrdata_q <= ahb_rd_word;
         end
      end
   end

   // -----------------------------------------
   // divider set storage
   // -----------------------------------------
   // the bus wins a collision; a serial byte waits while ahb_wr_q stays high, lost only if the next serial byte completes first
   assign i2c_take = i2c_wr_q & ~ahb_wr_q;
   assign i2c_in_map = (i2c_waddr_q[7:5] == 3'h0);
   assign sel_cfg = sets_q[sel_s];

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 4; i++) begin
            sets_q[i] <= PRESETS[i];
         end
      end else if (ahb_wr_q) begin
         sets_q[ahb_waddr_q[3:2]] <= field_wr(sets_q[ahb_waddr_q[3:2]], ahb_waddr_q[1:0], hwdata_in);
      end else if (i2c_take && i2c_in_map) begin
         sets_q[i2c_waddr_q[4:3]] <= byte_wr(sets_q[i2c_waddr_q[4:3]], i2c_waddr_q[2:0], i2c_wdata_q);
      end
   end

   // -----------------------------------------
   // active set and clock stand-in
   // -----------------------------------------
   // the analog synthesizer is outside; the post divider sets a half period here
   qps_pkg::qps_set_t act_q;
   logic [1:0] sel_last_q;
   logic [6:0] cnt_q, half_lim;
   logic       clk_q, comp_q, clk_oe_n_q, tick, sel_chg;

   assign half_lim = (act_q.post == 7'h00) ? 7'h01 : act_q.post;
   assign tick = (7'(cnt_q + 7'h01) >= half_lim);
   assign sel_chg = (sel_s != sel_last_q);

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         act_q <= PRESETS[0];
         sel_last_q <= 2'h0;
         cnt_q <= 7'h00;
         clk_q <= 1'b0;
         comp_q <= 1'b1;
         clk_oe_n_q <= 1'b0;
      end else begin
         // selected set steers, from sampled selects
         act_q <= sel_cfg;
         sel_last_q <= sel_s;
         clk_oe_n_q <= ~oe_s;
         if (sel_chg || tick) begin
            cnt_q <= 7'h00;
         end else begin
            cnt_q <= 7'(cnt_q + 7'h01);
         end
         if (tick && !sel_chg) begin
            clk_q <= ~clk_q;
            comp_q <= clk_q;
         end
      end
   end

   // -----------------------------------------
   // serial slave
   // -----------------------------------------
   logic [3:0] bitcnt_q;
   logic [7:0] shift_q, ptr_q, ptr_nx, rd_cur, rd_nxt;
   logic       rw_q, nack_q, sda_oe_n_q, sda_out_q;

   assign ptr_nx = 8'(ptr_q + 8'h01);
   assign rd_cur = byte_at(sets_q, ptr_q);
   assign rd_nxt = byte_at(sets_q, ptr_nx);

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         st_q <= qps_pkg::st_idle;
         bitcnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
         sda_out_q <= 1'b0;
         i2c_wr_q <= 1'b0;
         i2c_waddr_q <= 8'h00;
         i2c_wdata_q <= 8'h00;
      end else if (start_c) begin
         st_q <= qps_pkg::st_addr;
         bitcnt_q <= 4'h0;
         sda_oe_n_q <= 1'b1;
      end else if (stop_c) begin
         st_q <= qps_pkg::st_idle;
         sda_oe_n_q <= 1'b1;
      end else begin
         if (i2c_take) begin
            i2c_wr_q <= 1'b0;
         end
         if (scl_rise) begin
            bitcnt_q <= 4'(bitcnt_q + 4'h1);
            shift_q <= {shift_q[6:0], sda_s};
            nack_q <= sda_s;
         end
         if (scl_fall) begin
            case (st_q)
               qps_pkg::st_addr: begin
                  if (bitcnt_q == 4'h8) begin
                     if (shift_q[7:1] == `QPS_DEV_ADDR) begin
                        st_q <= qps_pkg::st_ack_a;
                        rw_q <= shift_q[0];
                        sda_oe_n_q <= 1'b0;
                     end else begin
                        st_q <= qps_pkg::st_idle;
                     end
                  end
               end
               qps_pkg::st_ack_a: begin
                  bitcnt_q <= 4'h0;
                  if (rw_q) begin
                     st_q <= qps_pkg::st_rdata;
                     shift_q <= rd_cur;
                     sda_oe_n_q <= rd_cur[7];
                  end else begin
                     st_q <= qps_pkg::st_reg;
                     sda_oe_n_q <= 1'b1;
                  end
               end
               qps_pkg::st_reg: begin
                  if (bitcnt_q == 4'h8) begin
                     ptr_q <= shift_q;
                     st_q <= qps_pkg::st_ack_r;
                     sda_oe_n_q <= 1'b0;
                  end
               end
               qps_pkg::st_ack_r, qps_pkg::st_ack_w: begin
                  bitcnt_q <= 4'h0;
                  st_q <= qps_pkg::st_wdata;
                  sda_oe_n_q <= 1'b1;
               end
               qps_pkg::st_wdata: begin
                  if (bitcnt_q == 4'h8) begin
                     i2c_wr_q <= 1'b1;
                     i2c_waddr_q <= ptr_q;
                     i2c_wdata_q <= shift_q;
                     ptr_q <= ptr_nx;
                     st_q <= qps_pkg::st_ack_w;
                     sda_oe_n_q <= 1'b0;
                  end
               end
               qps_pkg::st_rdata: begin
                  if (bitcnt_q == 4'h8) begin
                     st_q <= qps_pkg::st_rack;
                     sda_oe_n_q <= 1'b1;
                  end else begin
                     sda_oe_n_q <= shift_q[7];
                  end
               end
               qps_pkg::st_rack: begin
                  if (nack_q) begin
                     st_q <= qps_pkg::st_idle;
                  end else begin
                     ptr_q <= ptr_nx;
                     shift_q <= rd_nxt;
                     sda_oe_n_q <= rd_nxt[7];
                     bitcnt_q <= 4'h0;
                     st_q <= qps_pkg::st_rdata;
                  end
               end
               default: st_q <= qps_pkg::st_idle;
            endcase
         end
      end
   end

   // -----------------------------------------
   // outputs
   // -----------------------------------------
   assign hrdata_out = hrdata_q;
   assign hreadyout_out = hreadyout_q;
   assign hresp_out = hresp_q;
   assign serial_data_pin_out = sda_out_q;
   assign serial_data_pin_oe_n_out = sda_oe_n_q;
   assign cfg_active_out = act_q;
   assign clock_out_true_out = clk_q;
   assign clock_out_comp_out = comp_q;
   assign clock_out_oe_n_out = clk_oe_n_q;

   // -----------------------------------------
   // assertions
   // -----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence sel_moves;
      sel_chg;
   endsequence

   oe_follows_a: assert property (1'b1 |=> clk_oe_n_q == !$past(oe_s))
      else $error("output release does not follow enable");
   oe_fast_a: assert property ($fell(oe_s) |=> clk_oe_n_q ##1 clk_oe_n_q || $rose(oe_s))
      else $error("release waited after enable fell");
   select_map_a: assert property (1'b1 |=> act_q == $past(sel_cfg))
      else $error("active set differs from selected set");
   preset_load_a: assert property ($rose(reset_n_in) |-> sets_q[0] == `QPS_PRESET0 && sets_q[3] == `QPS_PRESET3)
      else $error("presets missing after reset");
   switch_now_a: assert property (sel_moves |=> cnt_q == 7'h00 && $stable(clk_q))
      else $error("select change did not restart output");
   unsel_write_a: assert property (ahb_wr_q && ahb_waddr_q[3:2] != sel_s |=> $stable(sel_cfg) || $changed(sel_s))
      else $error("write to unselected set changed output");
   sda_pull_only_a: assert property (!sda_oe_n_q |-> !sda_out_q && !(st_q inside {qps_pkg::st_idle, qps_pkg::st_reg}))
      else $error("data line driven out of turn");
   serial_write_a: assert property (i2c_take && i2c_in_map && i2c_waddr_q[2:0] == `QPS_B_FRAC_L |=>
      sets_q[$past(i2c_waddr_q[4:3])].frac[7:0] == $past(i2c_wdata_q))
      else $error("serial byte not stored");

endmodule

// >>> sim/qps_serial_host.sv
// two-wire serial host model that programs and reads back the divider sets
`timescale 1ns/10ps
`include "qps_cfg.svh"

module qps_serial_host (
   input  wire logic sda_line_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // ---------------------------------------------
   // bit level, 160 ns per bit
   // ---------------------------------------------
   // clock idles high, data only pulled low
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   // data is set 60 ns before the rise, so a late device release stays in the low phase
   task automatic send_bit(input logic b);
      sda_low_out = ~b;
      #60;
      scl_out = 1'b1;
      #80;
      scl_out = 1'b0;
      #20;
   endtask

   task automatic get_bit(output logic b);
      sda_low_out = 1'b0;
      #60;
      scl_out = 1'b1;
      #40;
      b = sda_line_in;
      #40;
      scl_out = 1'b0;
      #20;
   endtask

   // settle time first: the device may still hold its ack low
   task automatic frame_start();
      sda_low_out = 1'b0;
      #80;
      scl_out = 1'b1;
      #80;
      sda_low_out = 1'b1;
      #80;
      scl_out = 1'b0;
      #20;
   endtask

   task automatic frame_stop();
      sda_low_out = 1'b1;
      #60;
      scl_out = 1'b1;
      #80;
      sda_low_out = 1'b0;
      #80;
   endtask

   task automatic put_byte(input logic [7:0] b, inout logic [7:0] acks);
      logic nak;
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      get_bit(nak);
      acks = acks + {7'h0, ~nak};
   endtask

   // ---------------------------------------------
   // transactions
   // ---------------------------------------------
   // pointer then bytes, pointer auto-increments
   task automatic write_bytes(input logic [6:0] dev, input logic [7:0] ptr, input logic [47:0] d,
                              input int n, output logic [7:0] acks);
      acks = 8'h00;
      // step off the system clock edge so pin sampling never races the host
      #3;
      frame_start();
      put_byte({dev, 1'b0}, acks);
      put_byte(ptr, acks);
      for (int i = 0; i < n; i++) begin
         put_byte(d[47 - 8 * i -: 8], acks);
      end
      frame_stop();
   endtask

   // pointer write, repeated start, read with nack on the last byte
   task automatic read_bytes(input logic [7:0] ptr, input int n, output logic [47:0] d,
                             output logic [7:0] acks);
      logic [7:0] b;
      d    = 48'h0;
      acks = 8'h00;
      #3;
      frame_start();
      put_byte({`QPS_DEV_ADDR, 1'b0}, acks);
      put_byte(ptr, acks);
      frame_start();
      put_byte({`QPS_DEV_ADDR, 1'b1}, acks);
      for (int i = 0; i < n; i++) begin
         for (int k = 7; k >= 0; k--) begin
            get_bit(b[k]);
         end
         send_bit(i == n - 1);
         d[47 - 8 * i -: 8] = b;
      end
      frame_stop();
   endtask
endmodule

// >>> sim/quad_preset_freq_select_tb.sv
// self-checking bench of the preset selector: bus, selects, enable and serial link
`timescale 1ns/10ps
`include "qps_cfg.svh"

module quad_preset_freq_select_tb;
   logic              sys_clk_in     = 1'b0;
   logic              reset_n_in     = 1'b0;
   logic              hsel_in        = 1'b0;
   logic [31:0]       haddr_in       = 32'h0;
   logic [1:0]        htrans_in      = 2'h0;
   logic              hwrite_in      = 1'b0;
   logic [31:0]       hwdata_in      = 32'h0;
   logic [1:0]        rate_choice_in = 2'h0;
   logic              out_enable_in  = 1'b1;
   logic [31:0]       hrdata_out;
   logic              hreadyout_out;
   logic              hresp_out;
   logic              scl;
   logic              host_low;
   logic              sda_line;
   logic              sda_o;
   logic              sda_oe_n;
   logic              clk_t;
   logic              clk_c;
   logic              clk_oe_n;
   qps_pkg::qps_set_t cfg_active_out;
   int                n_mismatch     = 0;
   int                samples_checked = 0;
   logic [33:0]       presets [4]    = '{`QPS_PRESET0, `QPS_PRESET1, `QPS_PRESET2, `QPS_PRESET3};

   always #5 sys_clk_in = ~sys_clk_in;

   // wired line with pull-up, device only pulls low
   assign sda_line = (sda_oe_n === 1'b0 || host_low === 1'b1) ? 1'b0 : 1'b1;

   qps_top dut_u (
      .sys_clk_in               (sys_clk_in),
      .reset_n_in               (reset_n_in),
      .hsel_in                  (hsel_in),
      .haddr_in                 (haddr_in),
      .htrans_in                (htrans_in),
      .hwrite_in                (hwrite_in),
      .hsize_in                 (3'h2),
      .hwdata_in                (hwdata_in),
      .hready_in                (hreadyout_out),
      .hrdata_out               (hrdata_out),
      .hreadyout_out            (hreadyout_out),
      .hresp_out                (hresp_out),
      .rate_choice_in           (rate_choice_in),
      .out_enable_in            (out_enable_in),
      .serial_clk_in            (scl),
      .serial_data_pin_in       (sda_line),
      .serial_data_pin_out      (sda_o),
      .serial_data_pin_oe_n_out (sda_oe_n),
      .cfg_active_out           (cfg_active_out),
      .clock_out_true_out       (clk_t),
      .clock_out_comp_out       (clk_c),
      .clock_out_oe_n_out       (clk_oe_n)
   );

   qps_serial_host host_u (
      .sda_line_in (sda_line),
      .scl_out     (scl),
      .sda_low_out (host_low)
   );

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single transfer; hready is waited for, never assumed
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk_in);
      hsel_in   <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in  <= a;
      hwrite_in <= wr;
      @(posedge sys_clk_in);
      while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
      hsel_in   <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      @(posedge sys_clk_in);
      while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
      rd = hrdata_out;
      chk("response", 48'(hresp_out), 48'h0);
   endtask

   function automatic logic [31:0] adr(input int n, input int f);
      adr = 32'(n * 16 + f * 4);
   endfunction

   function automatic logic [31:0] fld(input qps_pkg::qps_set_t s, input int f);
      case (f)
         0: fld = {30'h0, s.pre};
         1: fld = {25'h0, s.whole};
         2: fld = {14'h0, s.frac};
         default: fld = {25'h0, s.post};
      endcase
   endfunction

   task automatic check_sets();
      logic [31:0] rd;
      for (int n = 0; n < 4; n++) begin
         for (int f = 0; f < 4; f++) begin
            bus(1'b0, adr(n, f), 32'h0, rd);
            chk("preset field", 48'(rd), 48'(fld(presets[n], f)));
         end
      end
   endtask

   // cycles between two toggles of the true clock output
   task automatic measure(output logic [31:0] n);
      logic v;
      int   t0;
      n  = 32'h0;
      t0 = -1;
      v  = clk_t;
      for (int k = 0; k < 600 && n == 0; k++) begin
         @(posedge sys_clk_in);
         #1;
         if (clk_t !== v) begin
            if (t0 >= 0) n = 32'(k - t0);
            t0 = k;
            v  = clk_t;
         end
      end
   endtask

   task automatic select(input logic [1:0] s);
      @(posedge sys_clk_in);
      rate_choice_in <= s;
      repeat (8) @(posedge sys_clk_in);
   endtask

   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      logic [31:0] rd;
      logic [47:0] got;
      logic [7:0]  acks;
      logic        v;
      logic [33:0] bus_set;
      logic [33:0] ser_set;
      // legal ranges, post 6 and 8
      bus_set = {2'h1, 7'h1e, 18'h00005, 7'h06};
      ser_set = {2'h2, 7'h28, 18'h12345, 7'h08};
      repeat (4) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      chk("power-up set", 48'(cfg_active_out), 48'(presets[0]));
      chk("clock driven", 48'(clk_oe_n), 48'h0);
      check_sets();
      bus(1'b0, 32'h44, 32'h0, rd);
      chk("reference", 48'(rd), 48'(`QPS_REF_A_KHZ));
      bus(1'b1, 32'h48, 32'h1234, rd);
      bus(1'b0, 32'h48, 32'h0, rd);
      chk("unmapped", 48'(rd), 48'h0);
      for (int s = 0; s < 4; s++) begin
         select(2'(s));
         chk("active set", 48'(cfg_active_out), 48'(presets[s]));
         measure(rd);
         chk("half period", 48'(rd), 48'(presets[s][6:0]));
         chk("complement", 48'(clk_c), {47'h0, ~clk_t});
      end
      select(2'h0);
      v = clk_t;
      while (clk_t === v) @(posedge sys_clk_in);
      out_enable_in <= 1'b0;
      v = clk_t;
      repeat (6) @(posedge sys_clk_in);
      #1;
      chk("outputs released", 48'(clk_oe_n), 48'h1);
      chk("no edge awaited", 48'(clk_t), 48'(v));
      @(posedge sys_clk_in);
      out_enable_in <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      chk("outputs driven", 48'(clk_oe_n), 48'h0);
      for (int f = 0; f < 4; f++) begin
         // post kept at 126, the top of its legal range
         bus(1'b1, adr(1, f), 32'hffffffff - 32'(f == 3), rd);
         bus(1'b0, adr(1, f), 32'h0, rd);
         chk("field width", 48'(rd), 48'(fld(34'h3fffffffe, f)));
         bus(1'b1, adr(1, f), fld(bus_set, f), rd);
      end
      chk("active kept", 48'(cfg_active_out), 48'(presets[0]));
      select(2'h1);
      chk("bus set taken", 48'(cfg_active_out), 48'(bus_set));
      bus(1'b0, 32'h40, 32'h0, rd);
      chk("status", 48'(rd), 48'h5);
      // serial write goes to the unselected set 2
      host_u.write_bytes(`QPS_DEV_ADDR, 8'h10, 48'h022801234508, 6, acks);
      chk("write acks", 48'(acks), 48'h8);
      for (int f = 0; f < 4; f++) begin
         bus(1'b0, adr(2, f), 32'h0, rd);
         chk("serial field", 48'(rd), 48'(fld(ser_set, f)));
      end
      chk("active kept", 48'(cfg_active_out), 48'(bus_set));
      host_u.read_bytes(8'h10, 6, got, acks);
      chk("read bytes", got, 48'h022801234508);
      chk("read acks", 48'(acks), 48'h3);
      host_u.write_bytes(7'h11, 8'h10, 48'h0, 1, acks);
      chk("foreign address", 48'(acks), 48'h0);
      chk("data pin level", 48'(sda_o), 48'h0);
      select(2'h2);
      chk("serial set taken", 48'(cfg_active_out), 48'(ser_set));
      @(posedge sys_clk_in);
      reset_n_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      repeat (10) @(posedge sys_clk_in);
      chk("power-up select", 48'(cfg_active_out), 48'(presets[2]));
      check_sets();
      conclude();
   end

   initial begin
      #500000;
      n_mismatch++;
      conclude();
   end
endmodule
